// [verilog/cycle_timer_interrupts.sv]
// Two global-time timers: cycle set plus macrotick offset, programmed over APB.
// Assumes the protocol timing logic drives cycle and macrotick on clk.
//
// Function
// - Two independent timers, each firing at chosen points of global time.
// - Each cycle set is nine bits: base cycle plus repetition.
// - Base cycle is six bits, register bits 5..0, first cycle of set.
// - Repetition is three bits, register bits 10..8; only 0..6 meaningful.
// - Sixteen-bit macrotick offset; fires when the count reaches it in set cycles.
// - Timer 0 cycle set at index 0x30; other bits reserved.
// - Timer 0 macrotick offset fills all sixteen bits at index 0x32.
// - Timer 1 cycle set at index 0x34, same fields as timer 0.
// - Timer 1 macrotick offset fills all sixteen bits at index 0x36.
// - Hard reset clears all four configuration registers.
`timescale 1ns/1ps
`default_nettype none

module cycle_timer_interrupts #(
	parameter int unsigned NUM_TIMERS = timer_pkg::NUM_TIMERS
) (
	// Clock and reset
	input  wire logic                                    clk,
	input  wire logic                                    sys_rst,
	// APB slave
	input  wire logic                                    psel,
	input  wire logic                                    penable,
	input  wire logic                                    pwrite,
	input  wire logic [9:0]                              paddr,
	input  wire logic [timer_pkg::DATA_W-1:0]            pwdata,
	input  wire logic [3:0]                              pstrb,
	output logic      [timer_pkg::DATA_W-1:0]            prdata,
	output logic                                         pready,
	output logic                                         pslverr,
	// Global time from the protocol timing logic
	input  wire timer_pkg::global_time_t                 gtime,
	// One-cycle timer events to the controller interrupt logic
	output logic      [NUM_TIMERS-1:0]                   timer_event
);

	timer_pkg::timer_cfg_t cfg_r [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] hit;
	logic [NUM_TIMERS-1:0] fired_r;
	logic                  setup;
	logic                  wr_access;
	logic                  mapped;
	logic [timer_pkg::DATA_W-1:0] rd_nxt;

	assign setup     = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign pready    = 1'b1;

	always_comb begin
		unique case (paddr)
			timer_pkg::ADR_T0_CYCLE_SET,
			timer_pkg::ADR_T0_TICK_OFFSET,
			timer_pkg::ADR_T1_CYCLE_SET,
			timer_pkg::ADR_T1_TICK_OFFSET,
			timer_pkg::ADR_STATUS: mapped = 1'b1;
			default:               mapped = 1'b0;
		endcase
	end

	// Unmapped access errors in the access phase
	assign pslverr = psel & penable & ~mapped;

	// Register writes, low two byte lanes only
	for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_cfg
		localparam logic [9:0] CS_ADR = (t == 0) ? timer_pkg::ADR_T0_CYCLE_SET
		                                         : timer_pkg::ADR_T1_CYCLE_SET;
		localparam logic [9:0] MO_ADR = (t == 0) ? timer_pkg::ADR_T0_TICK_OFFSET
		                                         : timer_pkg::ADR_T1_TICK_OFFSET;

		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				cfg_r[t] <= timer_pkg::timer_cfg_t'({9'h000, timer_pkg::CFG_RESET});
			end else if (wr_access) begin
				if (paddr == CS_ADR) begin
					if (pstrb[0]) begin
						cfg_r[t].cycle_set.base_f <=
							pwdata[timer_pkg::BASE_MSB:timer_pkg::BASE_LSB];
					end
					if (pstrb[1]) begin
						cfg_r[t].cycle_set.repeat_f <=
							pwdata[timer_pkg::REP_MSB:timer_pkg::REP_LSB];
					end
				end
				if (paddr == MO_ADR) begin
					if (pstrb[0]) begin
						cfg_r[t].tick_offset[7:0] <= pwdata[7:0];
					end
					if (pstrb[1]) begin
						cfg_r[t].tick_offset[15:8] <= pwdata[15:8];
					end
				end
			end
		end

		// Cycle set match and macrotick compare
		logic [timer_pkg::REP_W-1:0]   rep_eff;
		logic [timer_pkg::CYCLE_W-1:0] rep_mask;
		logic                          in_set;

		// Repetition values above six behave as six
		assign rep_eff  = (cfg_r[t].cycle_set.repeat_f > timer_pkg::REP_MAX)
		                ? timer_pkg::REP_MAX : cfg_r[t].cycle_set.repeat_f;
		assign rep_mask = timer_pkg::CYCLE_W'((7'd1 << rep_eff) - 7'd1);
		// Base not below 2^rep never matches; software must avoid it
		assign in_set   = ((gtime.cycle & rep_mask) == cfg_r[t].cycle_set.base_f);
		assign hit[t]   = gtime.tick_strobe & in_set
		                & (gtime.tick == cfg_r[t].tick_offset);
	end

	// Registered one-cycle event per timer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer_event <= '0;
		end else begin
			timer_event <= hit;
		end
	end

	// Fired-this-cycle flags; a hit wins over the cycle start clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fired_r <= '0;
		end else begin
			fired_r <= (gtime.cycle_start ? '0 : fired_r) | hit;
		end
	end

	// Read data mux
	always_comb begin
		rd_nxt = timer_pkg::RDATA_ZERO;
		unique case (paddr)
			timer_pkg::ADR_T0_CYCLE_SET: begin
				rd_nxt[timer_pkg::REP_MSB:timer_pkg::REP_LSB]   = cfg_r[0].cycle_set.repeat_f;
				rd_nxt[timer_pkg::BASE_MSB:timer_pkg::BASE_LSB] = cfg_r[0].cycle_set.base_f;
			end
			timer_pkg::ADR_T0_TICK_OFFSET: begin
				rd_nxt[15:0] = cfg_r[0].tick_offset;
			end
			timer_pkg::ADR_T1_CYCLE_SET: begin
				rd_nxt[timer_pkg::REP_MSB:timer_pkg::REP_LSB]   = cfg_r[1].cycle_set.repeat_f;
				rd_nxt[timer_pkg::BASE_MSB:timer_pkg::BASE_LSB] = cfg_r[1].cycle_set.base_f;
			end
			timer_pkg::ADR_T1_TICK_OFFSET: begin
				rd_nxt[15:0] = cfg_r[1].tick_offset;
			end
			timer_pkg::ADR_STATUS: begin
				rd_nxt[timer_pkg::ST_FIRED_LSB +: NUM_TIMERS]        = fired_r;
				rd_nxt[timer_pkg::ST_CYCLE_LSB +: timer_pkg::CYCLE_W] = gtime.cycle;
				rd_nxt[timer_pkg::ST_TICK_LSB +: timer_pkg::TICK_W]   = gtime.tick;
			end
			default: begin
				rd_nxt = timer_pkg::RDATA_ZERO;
			end
		endcase
	end

	// Read data captured in the setup phase, held through access
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= timer_pkg::RDATA_ZERO;
		end else if (setup & ~pwrite) begin
			prdata <= rd_nxt;
		end
	end

endmodule

`default_nettype wire

// [verilog/timer_pkg.sv]
// Constants and types for the cycle timer block.
// Assumes APB with 32-bit data; registers sit four bytes per printed index.
package timer_pkg;

	localparam int unsigned NUM_TIMERS   = 2;
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned CYCLE_W      = 6;
	localparam int unsigned REP_W        = 3;
	localparam int unsigned TICK_W       = 16;

	// Printed register indices
	localparam logic [ADDR_W-1:0] IDX_T0_CYCLE_SET   = 8'h30;
	localparam logic [ADDR_W-1:0] IDX_T0_TICK_OFFSET = 8'h32;
	localparam logic [ADDR_W-1:0] IDX_T1_CYCLE_SET   = 8'h34;
	localparam logic [ADDR_W-1:0] IDX_T1_TICK_OFFSET = 8'h36;
	localparam logic [ADDR_W-1:0] IDX_STATUS         = 8'h38;

	// Byte address is four times the index
	localparam logic [9:0] ADR_T0_CYCLE_SET   = {IDX_T0_CYCLE_SET, 2'b00};
	localparam logic [9:0] ADR_T0_TICK_OFFSET = {IDX_T0_TICK_OFFSET, 2'b00};
	localparam logic [9:0] ADR_T1_CYCLE_SET   = {IDX_T1_CYCLE_SET, 2'b00};
	localparam logic [9:0] ADR_T1_TICK_OFFSET = {IDX_T1_TICK_OFFSET, 2'b00};
	localparam logic [9:0] ADR_STATUS         = {IDX_STATUS, 2'b00};

	// Cycle set field positions
	localparam int unsigned BASE_LSB = 0;
	localparam int unsigned BASE_MSB = 5;
	localparam int unsigned REP_LSB  = 8;
	localparam int unsigned REP_MSB  = 10;

	// Status register field positions
	localparam int unsigned ST_FIRED_LSB = 0;
	localparam int unsigned ST_CYCLE_LSB = 8;
	localparam int unsigned ST_TICK_LSB  = 16;

	localparam logic [REP_W-1:0]  REP_MAX         = 3'h6;
	localparam logic [15:0]       CFG_RESET       = 16'h0000;
	localparam logic [DATA_W-1:0] RDATA_ZERO      = 32'h0000_0000;

	typedef struct packed {
		logic [REP_W-1:0]   repeat_f;
		logic [CYCLE_W-1:0] base_f;
	} cycle_set_t;

	typedef struct packed {
		cycle_set_t        cycle_set;
		logic [TICK_W-1:0] tick_offset;
	} timer_cfg_t;

	typedef struct packed {
		logic               cycle_start;
		logic               tick_strobe;
		logic [CYCLE_W-1:0] cycle;
		logic [TICK_W-1:0]  tick;
	} global_time_t;

endpackage

// [dv/timer_props.sv]
// Port checker for the cycle timer block.
// Assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module timer_props #(
	parameter int unsigned NUM_TIMERS = 2
) (
	// Clock and reset
	input wire logic                         clk,
	input wire logic                         sys_rst,
	// Bus
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [9:0]                   paddr,
	input wire logic [timer_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0]                   pstrb,
	input wire logic [timer_pkg::DATA_W-1:0] prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	// Time and events
	input wire timer_pkg::global_time_t      gtime,
	input wire logic [NUM_TIMERS-1:0]        timer_event
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic mapd = paddr inside {timer_pkg::ADR_T0_CYCLE_SET, timer_pkg::ADR_T0_TICK_OFFSET,
		timer_pkg::ADR_T1_CYCLE_SET, timer_pkg::ADR_T1_TICK_OFFSET, timer_pkg::ADR_STATUS};
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_rd_bad;
		psel && !penable && !pwrite && !mapd;
	endsequence
	AST_READY: assert property (s_acc |-> pready) else $error("no ready");
	AST_ERR_PHASE: assert property (pslverr |-> psel && penable && !mapd) else $error("err");
	AST_ERR_MAP: assert property (psel && penable && !mapd |-> pslverr) else $error("no err");
	AST_RD_UNMAP: assert property (s_rd_bad ##1 s_acc |-> prdata == timer_pkg::RDATA_ZERO)
		else $error("unmapped read data");
	AST_RD_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	AST_EV0_ONE: assert property (timer_event[0] |=> !timer_event[0]) else $error("ev0 long");
	AST_EV1_ONE: assert property (timer_event[1] |=> !timer_event[1]) else $error("ev1 long");
	AST_EV_CAUSE: assert property (|timer_event |-> $past(gtime.tick_strobe))
		else $error("event without tick");
	AST_EV_QUIET: assert property (!gtime.tick_strobe |=> timer_event == '0)
		else $error("event while idle");
endmodule
bind cycle_timer_interrupts timer_props #(.NUM_TIMERS(NUM_TIMERS)) props (.clk, .sys_rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .gtime, .timer_event);
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the cycle timer block.
// Assumes zero-wait APB and a timer event one cycle after a matching tick.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin errors++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
	logic                    clk, sys_rst, psel, penable, pwrite, pready, pslverr, stb_d;
	logic [9:0]              paddr;
	logic [3:0]              pstrb;
	logic [31:0]             pwdata, prdata, v, o;
	logic [32:0]             rq[$], rx;
	logic [1:0]              eq[$], ex, timer_event;
	timer_pkg::global_time_t gtime;
	int                      errors, total_checks, cycles, b0, b1, m;
	localparam logic [9:0] ADR[4] = '{timer_pkg::ADR_T0_CYCLE_SET, timer_pkg::ADR_T0_TICK_OFFSET,
		timer_pkg::ADR_T1_CYCLE_SET, timer_pkg::ADR_T1_TICK_OFFSET};
	localparam logic [9:0] ADR_ST = timer_pkg::ADR_STATUS;
	cycle_timer_interrupts uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .gtime(gtime), .timer_event(timer_event));
	task test_done;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task apb(input logic [9:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) rq.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (!pready) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task tick(input logic s, input logic [5:0] cy, input logic [15:0] t, input logic [1:0] e);
		@(posedge clk);
		gtime <= {s, 1'b1, cy, t};
		eq.push_back(e);
		@(posedge clk);
		gtime <= {2'b00, cy, t};
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Result monitor and timeout
	always @(posedge clk) begin
		stb_d <= gtime.tick_strobe;
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			test_done;
		end
		if (psel && penable && !pwrite && pready) begin
			rx = rq.pop_front();
			`CHK("read", rx, {pslverr, prdata})
		end
		if (stb_d) begin
			ex = eq.pop_front();
			`CHK("event", ex, timer_event)
		end
	end
	initial begin
		{sys_rst, psel, penable, pwrite, paddr, pwdata, gtime} = '0;
		pstrb = 4'hF;
		sys_rst = 1'b1;
		{stb_d, cycles, errors, total_checks} = '0;
		void'($urandom(32'h4108));
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (ADR[i]) apb(ADR[i], 1'b0, '0, '0);
		foreach (ADR[i]) begin
			v = $urandom;
			apb(ADR[i], 1'b1, v, '0);
			apb(ADR[i], 1'b0, '0, {1'b0, v & (i[0] ? 32'h0000_FFFF : 32'h0000_073F)});
		end
		apb(10'h3FC, 1'b0, '0, {1'b1, 32'h0000_0000});
		// Byte lanes: lane 0 low byte, lane 1 high byte
		apb(ADR[0], 1'b1, '0, '0);
		apb(ADR[1], 1'b1, '0, '0);
		pstrb <= 4'h1;
		apb(ADR[0], 1'b1, 32'hFFFF_FFFF, '0);
		pstrb <= 4'h2;
		apb(ADR[1], 1'b1, 32'hFFFF_FFFF, '0);
		pstrb <= 4'hF;
		apb(ADR[0], 1'b0, '0, {1'b0, 32'h0000_003F});
		apb(ADR[1], 1'b0, '0, {1'b0, 32'h0000_FF00});
		$display("register test done");
		for (int c = 0; c < 7; c++) begin
			m = (1 << c) - 1;
			b0 = $urandom % (1 << c);
			b1 = $urandom % 64;
			o = $urandom;
			apb(ADR[0], 1'b1, 32'(c << 8 | b0), '0);
			apb(ADR[1], 1'b1, o, '0);
			apb(ADR[2], 1'b1, 32'(c << 8 | b1), '0);
			apb(ADR[3], 1'b1, o, '0);
			for (int k = 0; k < 64; k++) begin
				tick(1'b0, 6'(k), o[15:0], {b1 <= m && (k & m) == b1, (k & m) == b0});
				tick(1'b0, 6'(k), o[15:0] + 16'h0001, 2'b00);
			end
			$display("timer test rep %0d done", c);
		end
		// Status: cycle start clears fired flags, a hit in the same cycle wins
		tick(1'b1, 6'(b0), o[15:0], {b1 == b0, 1'b1});
		apb(ADR_ST, 1'b0, '0, {1'b0, o[15:0], 2'b00, 6'(b0), 6'h00, b1 == b0, 1'b1});
		tick(1'b1, 6'(b0), o[15:0] + 16'h0001, 2'b00);
		apb(ADR_ST, 1'b0, '0, {1'b0, o[15:0] + 16'h0001, 2'b00, 6'(b0), 8'h00});
		$display("status test done");
		test_done;
	end
endmodule
`default_nettype wire
